// >>> core/ext_pin_pkg.sv
// constants for the shared external bus pin block
package ext_pin_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [3:0] OFS_PORT_ONE_DATA   = 4'h0;
  localparam logic [3:0] OFS_PORT_ONE_DIR    = 4'h1;
  localparam logic [3:0] OFS_PORT_THREE_DATA = 4'h2;
  localparam logic [3:0] OFS_PORT_THREE_DIR  = 4'h3;
  localparam logic [3:0] OFS_PORT_ZERO_DATA  = 4'h4;
  localparam logic [3:0] OFS_PORT_ZERO_DIR   = 4'h5;
  localparam logic [3:0] OFS_PIN_CONTROL     = 4'h6;
  localparam logic [3:0] OFS_DSP_PIN_DIR     = 4'h7;
  localparam logic [3:0] OFS_DSP_PIN_VALUE   = 4'h8;
  localparam logic [3:0] OFS_PORT_ONE_LEVEL  = 4'h9;
  localparam logic [3:0] OFS_PORT_THREE_LVL  = 4'hA;
  localparam logic [3:0] OFS_PORT_ZERO_LEVEL = 4'hB;
  localparam logic [3:0] OFS_DSP_PIN_LEVEL   = 4'hC;

  // pin_control_register fields
  localparam int BIT_READ_STROBE_DISABLE = 0;
  localparam int BIT_FETCH_PIN_SELECT    = 1;
  localparam int BIT_FETCH_PIN_BIT       = 2;
  localparam int BIT_DSP_SRAM_MODE       = 3;

  // port three pins handled here
  localparam int BIT_READ_PIN  = 7;
  localparam int BIT_STORE_PIN = 6;

  // port one pin with special reset and low-power behaviour
  localparam int BIT_P1_SPECIAL = 0;
  // first low bus pin that may serve as a port pin
  localparam int LOW_GPIO_FIRST = 2;

  // dsp address bits carried on the shared pins
  localparam int SRAM_BIT_A = 11;
  localparam int DRAM_BIT_A = 7;
  localparam int SRAM_BIT_B = 10;
  localparam int DRAM_BIT_B = 6;

  // reset values
  localparam logic [7:0] RST_PORT_ONE_DATA = 8'h00;
  localparam logic [7:0] RST_PORT_ONE_DIR  = 8'h01;
  localparam logic [7:0] RST_PORT_DATA     = 8'hFF;
  localparam logic [7:0] RST_PORT_DIR      = 8'h00;
  localparam logic [7:0] RST_PIN_CONTROL   = 8'h0C;
  localparam logic [7:0] RST_ZERO          = 8'h00;

endpackage

// >>> core/ext_bus_pin_share.sv
// pin sharing between external bus functions and port pins
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
module ext_bus_pin_share #(
  parameter int DSP_PINS_PER_CORE = 2
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // microcontroller core side
  input  wire logic        mcu_idle,
  input  wire logic        mcu_power_down,
  input  wire logic        ext_cycle,
  input  wire logic        addr_phase,
  input  wire logic        data_read,
  input  wire logic        data_write,
  input  wire logic        ext_fetch,
  input  wire logic        aux_fetch,
  input  wire logic        aux_access,
  input  wire logic [15:0] mcu_addr,
  input  wire logic [7:0]  mcu_wdata,
  output logic      [7:0]  mcu_rdata,
  // port one pins
  input  wire logic [7:0]  port_one_in,
  output logic      [7:0]  port_one_out,
  output logic      [7:0]  port_one_oe,
  // read and store strobe pins
  input  wire logic        read_pin_in,
  output logic             read_pin_out,
  output logic             read_pin_oe,
  input  wire logic        store_pin_in,
  output logic             store_pin_out,
  output logic             store_pin_oe,
  // latch_strobe and program_fetch_enable pins
  output logic             latch_strobe_out,
  output logic             latch_strobe_oe,
  output logic             fetch_pin_out,
  output logic             fetch_pin_oe,
  // low bus pins
  input  wire logic [7:0]  low_bus_in,
  output logic      [7:0]  low_bus_out,
  output logic      [7:0]  low_bus_oe,
  // high address pins
  output logic      [7:0]  high_addr_out,
  output logic      [7:0]  high_addr_oe,
  // dsp memory port
  input  wire logic [13:0] dsp_mem_addr,
  input  wire logic        dsp_mem_read_n,
  output logic             shared_addr_pin_a,
  output logic             shared_addr_pin_b,
  output logic             dsp_mem_read_enable,
  // dsp port pins, core 0 in the low half
  input  wire logic [2*DSP_PINS_PER_CORE-1:0] dsp_pin_in,
  output logic      [2*DSP_PINS_PER_CORE-1:0] dsp_pin_out,
  output logic      [2*DSP_PINS_PER_CORE-1:0] dsp_pin_oe
);

  localparam int DSP_W = 2 * DSP_PINS_PER_CORE;

  if (DSP_PINS_PER_CORE < 1 || DSP_PINS_PER_CORE > 4) begin : g_bad_param
    $error("DSP_PINS_PER_CORE must lie between 1 and 4");
  end

  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // software registers
  logic [7:0]       port_one_data;
  logic [7:0]       port_one_direction;
  logic [7:0]       port_three_data;
  logic [7:0]       port_three_direction;
  logic [7:0]       port_zero_data;
  logic [7:0]       port_zero_direction;
  logic [7:0]       pin_control_register;
  logic [DSP_W-1:0] dsp_pin_direction;
  logic [DSP_W-1:0] dsp_pin_value;

  wire read_strobe_disable = pin_control_register[ext_pin_pkg::BIT_READ_STROBE_DISABLE];
  wire fetch_pin_select    = pin_control_register[ext_pin_pkg::BIT_FETCH_PIN_SELECT];
  wire fetch_pin_bit       = pin_control_register[ext_pin_pkg::BIT_FETCH_PIN_BIT];
  wire dsp_sram_mode       = pin_control_register[ext_pin_pkg::BIT_DSP_SRAM_MODE];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_one_data        <= ext_pin_pkg::RST_PORT_ONE_DATA;
      port_one_direction   <= ext_pin_pkg::RST_PORT_ONE_DIR;
      port_three_data      <= ext_pin_pkg::RST_PORT_DATA;
      port_three_direction <= ext_pin_pkg::RST_PORT_DIR;
      port_zero_data       <= ext_pin_pkg::RST_PORT_DATA;
      port_zero_direction  <= ext_pin_pkg::RST_PORT_DIR;
      pin_control_register <= ext_pin_pkg::RST_PIN_CONTROL;
      dsp_pin_direction    <= '0;
      dsp_pin_value        <= '0;
    end else if (reg_write) begin
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_PORT_ONE_DATA))   port_one_data        <= reg_wdata;
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_PORT_ONE_DIR))    port_one_direction   <= reg_wdata;
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_PORT_THREE_DATA)) port_three_data      <= reg_wdata;
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_PORT_THREE_DIR))  port_three_direction <= reg_wdata;
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_PORT_ZERO_DATA))  port_zero_data       <= reg_wdata;
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_PORT_ZERO_DIR))   port_zero_direction  <= reg_wdata;
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_PIN_CONTROL))     pin_control_register <= reg_wdata;
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_DSP_PIN_DIR))     dsp_pin_direction    <= reg_wdata[DSP_W-1:0];
      if (reg_hit(reg_addr, ext_pin_pkg::OFS_DSP_PIN_VALUE))   dsp_pin_value        <= reg_wdata[DSP_W-1:0];
    end
  end

  // read decode, unmapped offsets read zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = ext_pin_pkg::RST_ZERO;
    unique case (reg_addr)
      ext_pin_pkg::OFS_PORT_ONE_DATA:   next_rdata = port_one_data;
      ext_pin_pkg::OFS_PORT_ONE_DIR:    next_rdata = port_one_direction;
      ext_pin_pkg::OFS_PORT_THREE_DATA: next_rdata = port_three_data;
      ext_pin_pkg::OFS_PORT_THREE_DIR:  next_rdata = port_three_direction;
      ext_pin_pkg::OFS_PORT_ZERO_DATA:  next_rdata = port_zero_data;
      ext_pin_pkg::OFS_PORT_ZERO_DIR:   next_rdata = port_zero_direction;
      ext_pin_pkg::OFS_PIN_CONTROL:     next_rdata = pin_control_register;
      ext_pin_pkg::OFS_DSP_PIN_DIR:     next_rdata[DSP_W-1:0] = dsp_pin_direction;
      ext_pin_pkg::OFS_DSP_PIN_VALUE:   next_rdata[DSP_W-1:0] = dsp_pin_value;
      ext_pin_pkg::OFS_PORT_ONE_LEVEL:  next_rdata = port_one_in;
      ext_pin_pkg::OFS_PORT_THREE_LVL:  next_rdata = {read_pin_in, store_pin_in, 6'h00};
      ext_pin_pkg::OFS_PORT_ZERO_LEVEL: next_rdata = low_bus_in;
      ext_pin_pkg::OFS_DSP_PIN_LEVEL:   next_rdata[DSP_W-1:0] = dsp_pin_in;
      default:                          next_rdata = ext_pin_pkg::RST_ZERO;
    endcase
  end

  // port one: low-power state forces pin zero high
  wire       low_power = mcu_idle | mcu_power_down;
  wire [7:0] next_p1_out;
  wire [7:0] next_p1_oe;
  assign next_p1_out = low_power ? (port_one_data | 8'h01) : port_one_data;
  assign next_p1_oe  = low_power ? (port_one_direction | 8'h01) : port_one_direction;

  // strobe pins owned by the bus for the whole external cycle, read pin only while read_strobe_disable is clear
  wire rd_owned  = ext_cycle & ~read_strobe_disable;
  wire wr_owned  = ext_cycle;
  wire next_rd_out = rd_owned ? ~data_read  : port_three_data[ext_pin_pkg::BIT_READ_PIN];
  wire next_rd_oe  = rd_owned | port_three_direction[ext_pin_pkg::BIT_READ_PIN];
  wire next_wr_out = wr_owned ? ~data_write : port_three_data[ext_pin_pkg::BIT_STORE_PIN];
  wire next_wr_oe  = wr_owned | port_three_direction[ext_pin_pkg::BIT_STORE_PIN];

  // latch strobe: address phase of genuine external accesses only
  wire next_latch = ext_cycle & addr_phase & ~aux_access;

  // fetch pin: external fetch strobe, or read strobe for internal extra ram
  wire aux_as_read = aux_fetch & fetch_pin_select;
  wire next_fetch  = ext_fetch   ? 1'b0 :
                     aux_as_read ? ~data_read : fetch_pin_bit;

  // low bus pins: address phase, write data, read turnaround, else port zero on pins 2 to 7 (pins 0 and 1 released)
  wire       low_bus_owned = ext_cycle;
  wire [7:0] bus_value     = addr_phase ? mcu_addr[7:0] : mcu_wdata;
  wire       bus_drive     = addr_phase | data_write;
  logic [7:0] next_low_out;
  logic [7:0] next_low_oe;
  for (genvar i = 0; i < 8; i++) begin : g_low_bus
    if (i >= ext_pin_pkg::LOW_GPIO_FIRST) begin : g_shared
      assign next_low_out[i] = low_bus_owned ? bus_value[i] : port_zero_data[i];
      assign next_low_oe[i]  = low_bus_owned ? bus_drive : port_zero_direction[i];
    end else begin : g_bus_only
      assign next_low_out[i] = bus_value[i];
      assign next_low_oe[i]  = low_bus_owned & bus_drive;
    end
  end

  // high address byte held from the last external cycle
  wire [7:0] next_high = ext_cycle ? mcu_addr[15:8] : high_addr_out;

  // dsp memory port shared pins
  wire next_pin_a = dsp_sram_mode ? dsp_mem_addr[ext_pin_pkg::SRAM_BIT_A]
                                  : dsp_mem_addr[ext_pin_pkg::DRAM_BIT_A];
  wire next_pin_b = dsp_sram_mode ? dsp_mem_addr[ext_pin_pkg::SRAM_BIT_B]
                                  : dsp_mem_addr[ext_pin_pkg::DRAM_BIT_B];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata           <= '0;
      mcu_rdata           <= '0;
      port_one_out        <= '0;
      port_one_oe         <= '0;
      read_pin_out        <= 1'b1;
      read_pin_oe         <= 1'b0;
      store_pin_out       <= 1'b1;
      store_pin_oe        <= 1'b0;
      latch_strobe_out    <= 1'b0;
      latch_strobe_oe     <= 1'b0;
      fetch_pin_out       <= 1'b1;
      fetch_pin_oe        <= 1'b0;
      low_bus_out         <= '0;
      low_bus_oe          <= '0;
      high_addr_out       <= '0;
      high_addr_oe        <= '0;
      shared_addr_pin_a   <= 1'b1;
      shared_addr_pin_b   <= 1'b1;
      dsp_mem_read_enable <= 1'b1;
      dsp_pin_out         <= '0;
      dsp_pin_oe          <= '0;
    end else begin
      reg_rdata           <= reg_read ? next_rdata : '0;
      mcu_rdata           <= (ext_cycle & data_read) ? low_bus_in : mcu_rdata;
      port_one_out        <= next_p1_out;
      port_one_oe         <= next_p1_oe;
      read_pin_out        <= next_rd_out;
      read_pin_oe         <= next_rd_oe;
      store_pin_out       <= next_wr_out;
      store_pin_oe        <= next_wr_oe;
      latch_strobe_out    <= next_latch;
      latch_strobe_oe     <= 1'b1;
      fetch_pin_out       <= next_fetch;
      fetch_pin_oe        <= 1'b1;
      low_bus_out         <= next_low_out;
      low_bus_oe          <= next_low_oe;
      high_addr_out       <= next_high;
      high_addr_oe        <= '1;
      shared_addr_pin_a   <= next_pin_a;
      shared_addr_pin_b   <= next_pin_b;
      dsp_mem_read_enable <= dsp_mem_read_n;
      dsp_pin_out         <= dsp_pin_value;
      dsp_pin_oe          <= dsp_pin_direction;
    end
  end

  // checks
  a_p1_reset_float: assert property (@(posedge ref_clk) !rst_n |=> !port_one_oe[0])
    else $error("port one pin zero driven during reset");

  a_p1_release_low: assert property (@(posedge ref_clk)
      $rose(rst_n) && !low_power |=> port_one_oe[0] && !port_one_out[0])
    else $error("port one pin zero not low after reset release");

  a_p1_power_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
      low_power |=> port_one_oe[0] && port_one_out[0])
    else $error("port one pin zero not high in low power");

  a_p1_follow_regs: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !low_power |=> port_one_oe == $past(port_one_direction)
                  && port_one_out == $past(port_one_data))
    else $error("port one pins do not follow registers");

  a_rd_strobe_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ext_cycle && data_read && !read_strobe_disable |=> read_pin_oe && !read_pin_out)
    else $error("read strobe not asserted");

  a_strobe_gpio_use: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !ext_cycle |=> store_pin_oe == $past(port_three_direction[ext_pin_pkg::BIT_STORE_PIN])
                  && read_pin_out == $past(port_three_data[ext_pin_pkg::BIT_READ_PIN]))
    else $error("strobe pins not under port three control");

  a_latch_addr_phase: assert property (@(posedge ref_clk) disable iff (!rst_n)
      latch_strobe_out |-> $past(addr_phase) && $past(ext_cycle) && low_bus_oe == 8'hFF)
    else $error("latch strobe outside address phase");

  a_latch_aux_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      aux_access |=> !latch_strobe_out)
    else $error("latch strobe during internal extra ram access");

  a_fetch_ext_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ext_fetch |=> !fetch_pin_out)
    else $error("program fetch enable not low");

  a_fetch_aux_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !ext_fetch && aux_fetch && fetch_pin_select |=> fetch_pin_out == !$past(data_read))
    else $error("fetch pin not acting as read strobe");

  a_low_addr_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ext_cycle && addr_phase |=> low_bus_out == $past(mcu_addr[7:0]))
    else $error("low bus address bits wrong");

  a_low_gpio_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !ext_cycle |=> low_bus_oe[7:2] == $past(port_zero_direction[7:2])
                  && low_bus_oe[1:0] == 2'b00)
    else $error("low bus port pins wrong");

  a_high_addr_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ext_cycle |=> high_addr_out == $past(mcu_addr[15:8]))
    else $error("high address pins wrong");

  a_dsp_mode_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !dsp_sram_mode |=> shared_addr_pin_a == $past(dsp_mem_addr[ext_pin_pkg::DRAM_BIT_A])
                      && shared_addr_pin_b == $past(dsp_mem_addr[ext_pin_pkg::DRAM_BIT_B]))
    else $error("dram mode routing wrong");

  a_dsp_read_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> dsp_mem_read_enable == $past(dsp_mem_read_n))
    else $error("dsp read enable not forwarded");

  a_dsp_pin_regs: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(dsp_pin_direction) |=> dsp_pin_oe == $past(dsp_pin_direction))
    else $error("dsp pin direction not applied");

endmodule // ext_bus_pin_share

// >>> test/ext_mem_model.sv
// behavioural external memory and peripheral on the shared low bus
`timescale 1ns/100ps
module ext_mem_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] low_bus_out,
  input  wire logic [7:0] low_bus_oe,
  input  wire logic       latch_strobe_out,
  input  wire logic       read_pin_out,
  input  wire logic       fetch_pin_out,
  output logic      [7:0] low_bus_in
);
  logic [7:0] held_addr;
  logic [7:0] filler = 8'h5A;
  wire        answering = (low_bus_oe == 8'h00) && !(read_pin_out && fetch_pin_out);
  always @(posedge ref_clk) begin
    filler <= ~filler;
    if (latch_strobe_out) begin
      held_addr <= low_bus_out;
    end
  end
  // released bus toggles so a stale byte never passes for read data
  assign low_bus_in = answering ? (held_addr ^ 8'hA5) : filler;
endmodule // ext_mem_model

// >>> test/mcu_ext_bus_pin_sharing_tb.sv
// self-checking bench for the shared external bus pin block
`timescale 1ns/100ps
module mcu_ext_bus_pin_sharing_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n, reg_write, reg_read, mcu_idle, mcu_power_down, ext_cycle, addr_phase;
  logic        data_read, data_write, ext_fetch, aux_fetch, aux_access, read_pin_in, store_pin_in;
  logic        dsp_mem_read_n, read_pin_out, read_pin_oe, store_pin_out, store_pin_oe;
  logic        latch_strobe_out, latch_strobe_oe, fetch_pin_out, fetch_pin_oe;
  logic        shared_addr_pin_a, shared_addr_pin_b, dsp_mem_read_enable;
  logic [3:0]  reg_addr, dsp_pin_in, dsp_pin_out, dsp_pin_oe;
  logic [7:0]  reg_wdata, reg_rdata, mcu_wdata, mcu_rdata, port_one_in, port_one_out, port_one_oe;
  logic [7:0]  low_bus_in, low_bus_out, low_bus_oe, high_addr_out, high_addr_oe;
  logic [13:0] dsp_mem_addr;
  logic [15:0] mcu_addr;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;

  ext_bus_pin_share uut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .mcu_idle, .mcu_power_down, .ext_cycle, .addr_phase, .data_read, .data_write, .ext_fetch,
    .aux_fetch, .aux_access, .mcu_addr, .mcu_wdata, .mcu_rdata, .port_one_in, .port_one_out,
    .port_one_oe, .read_pin_in, .read_pin_out, .read_pin_oe, .store_pin_in, .store_pin_out,
    .store_pin_oe, .latch_strobe_out, .latch_strobe_oe, .fetch_pin_out, .fetch_pin_oe, .low_bus_in,
    .low_bus_out, .low_bus_oe, .high_addr_out, .high_addr_oe, .dsp_mem_addr, .dsp_mem_read_n,
    .shared_addr_pin_a, .shared_addr_pin_b, .dsp_mem_read_enable, .dsp_pin_in, .dsp_pin_out,
    .dsp_pin_oe);
  ext_mem_model mem (.ref_clk, .low_bus_out, .low_bus_oe, .latch_strobe_out, .read_pin_out,
    .fetch_pin_out, .low_bus_in);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic t_reset();
    repeat (15) @(posedge ref_clk);
    #1 chk(port_one_oe[0], 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    settle();
    chk({port_one_oe[0], port_one_out[0]}, 2'b10);
    rd(ext_pin_pkg::OFS_PIN_CONTROL, 8'h0C);
    wr(4'hE, 8'hFF);
    rd(4'hE, 8'h00);
  endtask
  task automatic t_low_power();
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      {mcu_power_down, mcu_idle} <= 2'b01 << i;
      settle();
      chk({port_one_oe[0], port_one_out[0]}, 2'b11);
      @(posedge ref_clk);
      {mcu_power_down, mcu_idle} <= 2'b00;
      settle();
      chk({port_one_oe[0], port_one_out[0]}, 2'b10);
    end
  endtask
  task automatic t_port_one();
    wr(ext_pin_pkg::OFS_PORT_ONE_DIR, 8'hF0);
    wr(ext_pin_pkg::OFS_PORT_ONE_DATA, 8'h5A);
    settle();
    chk({port_one_oe, port_one_out}, 16'hF05A);
    wr(ext_pin_pkg::OFS_PORT_ONE_LEVEL, 8'h00);
    rd(ext_pin_pkg::OFS_PORT_ONE_LEVEL, 8'h3C);
  endtask
  task automatic t_ext_read();
    wr(ext_pin_pkg::OFS_PORT_ZERO_DIR, 8'hFC);
    wr(ext_pin_pkg::OFS_PORT_ZERO_DATA, 8'hA8);
    settle();
    chk({low_bus_oe, low_bus_out[7:2]}, {8'hFC, 6'h2A});
    @(posedge ref_clk);
    ext_cycle  <= 1'b1;
    addr_phase <= 1'b1;
    mcu_addr   <= 16'h1234;
    settle();
    chk({latch_strobe_oe, latch_strobe_out, low_bus_oe, low_bus_out}, {2'b11, 16'hFF34});
    chk({high_addr_oe, high_addr_out}, 16'hFF12);
    @(posedge ref_clk);
    addr_phase <= 1'b0;
    data_read  <= 1'b1;
    settle();
    chk({latch_strobe_out, low_bus_oe, read_pin_out}, 10'h000);
    settle();
    chk(mcu_rdata, 8'h34 ^ 8'hA5);
    @(posedge ref_clk);
    data_read  <= 1'b0;
    addr_phase <= 1'b1;
    aux_access <= 1'b1;
    settle();
    chk(latch_strobe_out, 1'b0);
    @(posedge ref_clk);
    {addr_phase, aux_access, data_write} <= 3'b001;
    mcu_wdata <= 8'hC3;
    settle();
    chk({low_bus_oe, low_bus_out}, 16'hFFC3);
    chk({store_pin_oe, store_pin_out, read_pin_out}, 3'b101);
    @(posedge ref_clk);
    {ext_cycle, data_write} <= 2'b00;
    settle();
    chk({low_bus_oe, low_bus_out[7:2]}, {8'hFC, 6'h2A});
  endtask
  task automatic t_read_disable();
    wr(ext_pin_pkg::OFS_PORT_THREE_DIR, 8'hC0);
    wr(ext_pin_pkg::OFS_PORT_THREE_DATA, 8'h80);
    settle();
    chk({read_pin_oe, read_pin_out, store_pin_oe, store_pin_out}, 4'b1110);
    rd(ext_pin_pkg::OFS_PORT_THREE_LVL, 8'h80);
    wr(ext_pin_pkg::OFS_PIN_CONTROL, 8'h0D);
    @(posedge ref_clk);
    ext_cycle <= 1'b1;
    data_read <= 1'b1;
    settle();
    chk({read_pin_oe, read_pin_out}, 2'b11);
    @(posedge ref_clk);
    {ext_cycle, data_read} <= 2'b00;
    wr(ext_pin_pkg::OFS_PIN_CONTROL, 8'h0C);
  endtask
  task automatic t_fetch();
    @(posedge ref_clk);
    ext_fetch <= 1'b1;
    settle();
    chk({fetch_pin_oe, fetch_pin_out}, 2'b10);
    @(posedge ref_clk);
    {ext_fetch, aux_fetch, data_read} <= 3'b011;
    settle();
    chk(fetch_pin_out, 1'b1);
    wr(ext_pin_pkg::OFS_PIN_CONTROL, 8'h0A);
    settle();
    chk(fetch_pin_out, 1'b0);
    @(posedge ref_clk);
    data_read <= 1'b0;
    settle();
    chk(fetch_pin_out, 1'b1);
    @(posedge ref_clk);
    aux_fetch <= 1'b0;
    settle();
    chk(fetch_pin_out, 1'b0);
  endtask
  task automatic t_dsp();
    @(posedge ref_clk);
    dsp_mem_addr   <= 14'h0840;
    dsp_mem_read_n <= 1'b0;
    settle();
    chk({shared_addr_pin_a, shared_addr_pin_b, dsp_mem_read_enable}, 3'b100);
    wr(ext_pin_pkg::OFS_PIN_CONTROL, 8'h02);
    @(posedge ref_clk);
    dsp_mem_read_n <= 1'b1;
    settle();
    chk({shared_addr_pin_a, shared_addr_pin_b, dsp_mem_read_enable}, 3'b011);
    wr(ext_pin_pkg::OFS_DSP_PIN_DIR, 8'h05);
    wr(ext_pin_pkg::OFS_DSP_PIN_VALUE, 8'hFC);
    settle();
    chk({dsp_pin_oe, dsp_pin_out & dsp_pin_oe}, 8'h54);
    rd(ext_pin_pkg::OFS_DSP_PIN_VALUE, 8'h0C);
    rd(ext_pin_pkg::OFS_DSP_PIN_LEVEL, 8'h09);
  endtask

  initial begin
    {rst_n, reg_write, reg_read, mcu_idle, mcu_power_down, ext_cycle, addr_phase} = '0;
    {data_read, data_write, ext_fetch, aux_fetch, aux_access} = '0;
    {read_pin_in, store_pin_in, dsp_mem_read_n} = 3'b101;
    reg_addr     = 4'h0;
    reg_wdata    = 8'h00;
    mcu_addr     = 16'h0000;
    mcu_wdata    = 8'h00;
    port_one_in  = 8'h3C;
    dsp_pin_in   = 4'h9;
    dsp_mem_addr = 14'h0000;
    t_reset();
    t_low_power();
    t_port_one();
    t_ext_read();
    t_read_disable();
    t_fetch();
    t_dsp();
    tally_and_finish();
  end
endmodule // mcu_ext_bus_pin_sharing_tb
